// [include/sep_pkg.sv]
// Constants, state types and bit positions for the dual-mode serial EEPROM port.
// Assumes one system clock domain plus the four-wire link clock.
package sep_pkg;
   // ----------------------------------------
   // Array geometry
   // ----------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int PAGE_IDX_W = 2;
   localparam int PAGE_BYTES = 4;
   localparam logic [7:0] ADDR_RESET = 8'h00;
   // ----------------------------------------
   // Four-wire opcodes and two-wire chip address
   // ----------------------------------------
   localparam logic [7:0] OPC_READ = 8'ha7;
   localparam logic [7:0] OPC_PROG_EN = 8'ha6;
   localparam logic [7:0] OPC_PROG_DIS = 8'ha4;
   localparam logic [7:0] OPC_WRITE = 8'ha2;
   localparam logic [3:0] CHIP_FIXED = 4'ha;
   // ----------------------------------------
   // Bit counts
   // ----------------------------------------
   localparam logic [3:0] TW_BIT_LAST = 4'h7;
   localparam logic [3:0] TW_ACK_BIT = 4'h8;
   localparam logic [2:0] FW_BIT_LAST = 3'h7;
   localparam logic [2:0] FW_BIT_FIRST = 3'h0;
   // ----------------------------------------
   // Synchroniser vector positions and idle levels
   // ----------------------------------------
   localparam int SY_MODE = 0;
   localparam int SY_CSU = 1;
   localparam int SY_CSL = 2;
   localparam int SY_SCL = 3;
   localparam int SY_SDA = 4;
   localparam int SY_SEL = 5;
   localparam int SY_TOG = 6;
   localparam int SY_W = 7;
   localparam logic [SY_W-1:0] SY_IDLE = 7'h38;
   // ----------------------------------------
   // State types
   // ----------------------------------------
   typedef enum logic [2:0] {TW_STBY, TW_CHIP, TW_WADDR, TW_WDATA, TW_RDATA} sep_tw_state_t;
   typedef enum logic [2:0] {FW_OPC, FW_ADDR, FW_DATA, FW_DONE, FW_DEAD} sep_fw_state_t;
endpackage

// [include/sep_mem_if.sv]
// Carrier between the port controller and its byte array.
// Assumes one write and one registered read per system clock.
interface sep_mem_if #(parameter int AW = 8, parameter int DW = 8);
   logic [AW-1:0] rd_addr;
   logic [DW-1:0] rd_data;
   logic wr_en;
   logic [AW-1:0] wr_addr;
   logic [DW-1:0] wr_data;
   modport ctrl (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
   modport mem (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface

// [core/sep_mem.sv]
// Byte array of the EEPROM, one write port and a registered read port.
// Assumes the controller holds the read address steady between uses.
module sep_mem #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   // Clock
   input wire logic i_sys_clk,
   // Array access
   sep_mem_if.mem mif
);
   logic [DW-1:0] cells [2**AW];

   // Contents are not reset: nonvolatile by nature
   always_ff @(posedge i_sys_clk) begin
      if (mif.wr_en) begin
         cells[mif.wr_addr] <= mif.wr_data;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      mif.rd_data <= cells[mif.rd_addr];
   end
endmodule // sep_mem

// [core/sep_port.sv]
// Two-wire and four-wire slave access and programming control of a 256-byte EEPROM.
// Assumes pins arrive unsynchronised; the four-wire clock comes from the master.
// ----------------------------------------
// Operation
// ----------------------------------------
// Operation
// - Two-wire: stop after read or address-only write returns to standby; mismatch too.
// - Two-wire: stop or new start after data bytes begins programming.
// - Two-wire programming ends at next valid selection of this chip.
// - Bad or foreign chip addresses leave ongoing programming running.
// - Up to four bytes of one page programmed together; address increments per byte.
// - Two-wire reads advance the address after every sent byte, the last included.
// - Read continues while master acknowledges; otherwise release data and go standby.
// - SDA falling with SCL high is start; rising with SCL high is stop.
// - Receiver pulls acknowledge low; transmitter releases SDA in the acknowledge slot.
// - Four-wire works only while select is low; otherwise output released.
// - First byte after select falls is the opcode for that selection.
// - Read opcode returns address then data; write opcode loads programming data.
// - Enable opcode sets program enable and supply; disable opcode clears both.
// - Unknown opcode: ignore input, output released until select falls again.
// - Four-wire bits captured on rising clock, output changed on falling clock.
// - Select high: standby after reset, disable, or read without pending enable.
// - Four-wire read: opcode, address, then incrementing data; input ignored afterwards.
// - Four-wire: current address sent first, new address echoed before data.
// - Four-wire programs only with enable set and write data; enable blocks standby.
// - Programming starts on deselect after write if enabled, or after later enable.
// - New selection suspends programming; read, write or unknown opcode ends it.
// - Chip address is 1010X then two bits matching the chip select pins.
// - Bit after chip address: low means master writes, high means device sends.
// - First byte after chip address loads the byte address register.
// - Reset: standby, outputs released, programming off, supply off, address zero.
module sep_port
   import sep_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_srst,
   // Straps
   input wire logic i_mode_sel,
   input wire logic i_chip_sel_upper_pin,
   input wire logic i_chip_sel_lower_pin,
   // Two-wire bus
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe_n,
   // Four-wire bus
   input wire logic i_four_wire_clock_in,
   input wire logic i_select_n_line,
   input wire logic i_serial_data_in_line,
   output logic o_serial_data_out_line,
   output logic o_serial_data_out_oe_n,
   // Status
   output logic o_standby,
   output logic o_prog_active,
   output logic o_prog_enable,
   output logic o_prog_supply_on
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [SY_W-1:0] pin_raw, pin_m, pin_s, pin_q;
   logic mode, scl_s, scl_q, sda_s, sda_q, sel_s, sel_q;
   logic tw_rise, tw_fall, tw_start, tw_stop, tw_byte_done, tw_chip_ok, tw_sel_ok, tw_ack_rise;
   logic [7:0] tw_byte, tw_sh, tx_sh;
   logic [3:0] tw_cnt;
   logic drive, ack_due;
   sep_tw_state_t tw_state;
   sep_fw_state_t fw_state;
   logic fw_ev, fw_rd, pe_ff, opc_known, sel_fall, sel_rise;
   logic [7:0] tx_hold;
   logic [2:0] lk_cnt, lk_oidx;
   logic [7:0] lk_sh, lk_rx, lk_txl;
   logic lk_tog;
   logic [ADDR_W-1:0] addr;
   logic addr_load, addr_inc, page_load, page_clr, prog_start, prog_stop;
   logic [7:0] in_byte;
   logic [DATA_W-1:0] page_dat [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] page_vld;
   logic [ADDR_W-PAGE_IDX_W-1:0] page_base;
   logic pend, prog_active;
   logic [PAGE_IDX_W-1:0] commit_idx;

   sep_mem_if #(.AW(ADDR_W), .DW(DATA_W)) mif ();

   sep_mem #(.AW(ADDR_W), .DW(DATA_W)) u_mem (
      .i_sys_clk(i_sys_clk),
      .mif(mif)
   );

   function automatic logic [PAGE_IDX_W-1:0] first_set(input logic [PAGE_BYTES-1:0] v);
      first_set = '0;
      for (int i = PAGE_BYTES - 1; i >= 0; i--) begin
         if (v[i]) begin
            first_set = PAGE_IDX_W'(i);
         end
      end
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   assign pin_raw = {lk_tog, i_select_n_line, i_sda, i_scl, i_chip_sel_lower_pin,
                     i_chip_sel_upper_pin, i_mode_sel};

   // Third stage feeds edge detection so the first stage stays clean
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         // Mode strap keeps moving through the chain so reset can capture it
         pin_m <= {SY_IDLE[SY_W-1:1], pin_raw[SY_MODE]};
         pin_s <= {SY_IDLE[SY_W-1:1], pin_m[SY_MODE]};
         pin_q <= SY_IDLE;
      end else begin
         pin_m <= pin_raw;
         pin_s <= pin_m;
         pin_q <= pin_s;
      end
   end

   // Mode is a strap: sampled during reset, frozen afterwards
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         mode <= pin_s[SY_MODE];
      end
   end

   assign scl_s = pin_s[SY_SCL];
   assign scl_q = pin_q[SY_SCL];
   assign sda_s = pin_s[SY_SDA];
   assign sda_q = pin_q[SY_SDA];
   assign sel_s = pin_s[SY_SEL];
   assign sel_q = pin_q[SY_SEL];

   // ----------------------------------------
   // Two-wire decode
   // ----------------------------------------
   assign tw_rise = ~mode & scl_s & ~scl_q;
   assign tw_fall = ~mode & ~scl_s & scl_q;
   assign tw_start = ~mode & scl_s & scl_q & sda_q & ~sda_s;
   assign tw_stop = ~mode & scl_s & scl_q & ~sda_q & sda_s;
   assign tw_byte = {tw_sh[6:0], sda_s};
   assign tw_byte_done = tw_rise & (tw_cnt == TW_BIT_LAST) & (tw_state != TW_STBY);
   assign tw_ack_rise = tw_rise & (tw_cnt == TW_ACK_BIT) & (tw_state != TW_STBY);
   assign tw_chip_ok = (tw_byte[7:4] == CHIP_FIXED) & (tw_byte[2] == pin_s[SY_CSU]) &
                       (tw_byte[1] == pin_s[SY_CSL]);
   assign tw_sel_ok = tw_byte_done & (tw_state == TW_CHIP) & tw_chip_ok;

   // ----------------------------------------
   // Two-wire sequencer
   // ----------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         tw_state <= TW_STBY;
         tw_cnt <= 4'h0;
         tw_sh <= 8'h00;
         tx_sh <= 8'h00;
         ack_due <= 1'b0;
         drive <= 1'b0;
      end else if (tw_start) begin
         tw_state <= TW_CHIP;
         tw_cnt <= 4'h0;
         ack_due <= 1'b0;
         drive <= 1'b0;
      end else if (tw_stop) begin
         tw_state <= TW_STBY;
         drive <= 1'b0;
      end else if (tw_rise && tw_state != TW_STBY) begin
         if (tw_cnt == TW_ACK_BIT) begin
            tw_cnt <= 4'h0;
            if (tw_state == TW_RDATA) begin
               if (sda_s) begin
                  tw_state <= TW_STBY;
               end else begin
                  tx_sh <= mif.rd_data;
               end
            end
         end else begin
            tw_sh <= tw_byte;
            tw_cnt <= tw_cnt + 4'h1;
            if (tw_cnt == TW_BIT_LAST) begin
               ack_due <= (tw_state != TW_RDATA) & ((tw_state != TW_CHIP) | tw_chip_ok);
               unique case (tw_state)
                  TW_CHIP: begin
                     if (!tw_chip_ok) begin
                        tw_state <= TW_STBY;
                     end else if (tw_byte[0]) begin
                        tw_state <= TW_RDATA;
                        tx_sh <= mif.rd_data;
                     end else begin
                        tw_state <= TW_WADDR;
                     end
                  end
                  TW_WADDR: tw_state <= TW_WDATA;
                  TW_WDATA, TW_RDATA, TW_STBY: tw_state <= tw_state;
               endcase
            end
         end
      end else if (tw_fall && tw_state != TW_STBY) begin
         // Transmitter lets go in the acknowledge slot
         if (tw_cnt == TW_ACK_BIT) begin
            drive <= ack_due;
         end else begin
            drive <= (tw_state == TW_RDATA) & ~tx_sh[3'h7 - tw_cnt[2:0]];
         end
      end
   end

   assign o_sda_out = 1'b0;
   assign o_sda_oe_n = ~drive;

   // ----------------------------------------
   // Four-wire link domain
   // ----------------------------------------
   // Select high holds the shifter clear, so a deselected bus is ignored
   always_ff @(posedge i_four_wire_clock_in or posedge i_select_n_line) begin
      if (i_select_n_line) begin
         lk_cnt <= FW_BIT_FIRST;
         lk_sh <= 8'h00;
      end else begin
         lk_sh <= {lk_sh[6:0], i_serial_data_in_line};
         lk_cnt <= lk_cnt + 3'h1;
      end
   end

   // Byte handover by toggle; the byte stays put for a whole byte time
   always_ff @(posedge i_four_wire_clock_in or posedge i_srst) begin
      if (i_srst) begin
         lk_rx <= 8'h00;
         lk_tog <= 1'b0;
      end else if (lk_cnt == FW_BIT_LAST && !i_select_n_line) begin
         lk_rx <= {lk_sh[6:0], i_serial_data_in_line};
         lk_tog <= ~lk_tog;
      end
   end

   // tx_hold is rewritten a few system clocks after each byte and stable
   // at the falling edge that opens the next byte
   always_ff @(negedge i_four_wire_clock_in or posedge i_select_n_line) begin
      if (i_select_n_line) begin
         lk_oidx <= FW_BIT_FIRST;
         lk_txl <= 8'h00;
      end else begin
         lk_oidx <= lk_oidx + 3'h1;
         if (lk_oidx == FW_BIT_FIRST) begin
            lk_txl <= tx_hold;
         end
      end
   end

   assign o_serial_data_out_line = (lk_oidx == FW_BIT_FIRST) ? tx_hold[7] :
                                   lk_txl[3'h7 - lk_oidx];

   // ----------------------------------------
   // Four-wire command control
   // ----------------------------------------
   assign sel_fall = mode & sel_q & ~sel_s;
   assign sel_rise = mode & ~sel_q & sel_s;
   assign fw_ev = mode & ~sel_s & (pin_s[SY_TOG] ^ pin_q[SY_TOG]);
   assign opc_known = (lk_rx == OPC_READ) | (lk_rx == OPC_WRITE) |
                      (lk_rx == OPC_PROG_EN) | (lk_rx == OPC_PROG_DIS);

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         fw_state <= FW_OPC;
         fw_rd <= 1'b0;
         pe_ff <= 1'b0;
         tx_hold <= 8'h00;
      end else if (sel_fall) begin
         fw_state <= FW_OPC;
         tx_hold <= addr;
      end else if (fw_ev) begin
         unique case (fw_state)
            FW_OPC: begin
               tx_hold <= 8'h00;
               unique case (lk_rx)
                  OPC_READ: begin
                     fw_rd <= 1'b1;
                     fw_state <= FW_ADDR;
                  end
                  OPC_WRITE: begin
                     fw_rd <= 1'b0;
                     fw_state <= FW_ADDR;
                  end
                  OPC_PROG_EN: begin
                     pe_ff <= 1'b1;
                     fw_state <= FW_DONE;
                  end
                  OPC_PROG_DIS: begin
                     pe_ff <= 1'b0;
                     fw_state <= FW_DONE;
                  end
                  default: fw_state <= FW_DEAD;
               endcase
            end
            FW_ADDR: begin
               tx_hold <= lk_rx;
               fw_state <= FW_DATA;
            end
            FW_DATA: tx_hold <= fw_rd ? mif.rd_data : 8'h00;
            FW_DONE, FW_DEAD: tx_hold <= 8'h00;
         endcase
      end
   end

   assign o_serial_data_out_oe_n = ~(mode & ~sel_s & (fw_state != FW_DEAD));

   // ----------------------------------------
   // Byte address
   // ----------------------------------------
   assign in_byte = mode ? lk_rx : tw_byte;
   assign addr_load = (tw_byte_done & (tw_state == TW_WADDR)) | (fw_ev & (fw_state == FW_ADDR));
   assign addr_inc = (tw_byte_done & ((tw_state == TW_WDATA) | (tw_state == TW_RDATA))) |
                     (fw_ev & (fw_state == FW_DATA));

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         addr <= ADDR_RESET;
      end else if (addr_load) begin
         addr <= in_byte;
      end else if (addr_inc) begin
         addr <= addr + 8'h01;
      end
   end

   // ----------------------------------------
   // Page latch and programming
   // ----------------------------------------
   assign page_load = (tw_byte_done & (tw_state == TW_WDATA)) |
                      (fw_ev & (fw_state == FW_DATA) & ~fw_rd);
   // Read, write and bad opcodes all drop latched data
   assign page_clr = tw_sel_ok | (fw_ev & (fw_state == FW_OPC) &
                     ((lk_rx == OPC_READ) | (lk_rx == OPC_WRITE) | ~opc_known));
   assign prog_start = ((tw_start | tw_stop) & pend) |
                       (sel_rise & pe_ff & pend);
   assign prog_stop = tw_sel_ok | sel_fall |
                      (fw_ev & (fw_state == FW_OPC) & ((lk_rx == OPC_READ) |
                      (lk_rx == OPC_PROG_EN) | (lk_rx == OPC_PROG_DIS)));
   assign commit_idx = first_set(page_vld);

   // Array is written as soon as programming begins; duration is not modelled
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         page_vld <= '0;
         page_base <= '0;
         pend <= 1'b0;
      end else begin
         if (page_clr) begin
            page_vld <= '0;
            pend <= 1'b0;
         end else if (prog_active && page_vld != '0) begin
            page_vld[commit_idx] <= 1'b0;
         end
         // Loading wins over a same-cycle clear
         if (page_load) begin
            page_dat[addr[PAGE_IDX_W-1:0]] <= in_byte;
            page_vld[addr[PAGE_IDX_W-1:0]] <= 1'b1;
            page_base <= addr[ADDR_W-1:PAGE_IDX_W];
            pend <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         prog_active <= 1'b0;
      end else if (prog_start) begin
         prog_active <= 1'b1;
      end else if (prog_stop) begin
         prog_active <= 1'b0;
      end
   end

   assign mif.rd_addr = addr;
   assign mif.wr_en = prog_active & (page_vld != '0);
   assign mif.wr_addr = {page_base, commit_idx};
   assign mif.wr_data = page_dat[commit_idx];

   // ----------------------------------------
   // Status
   // ----------------------------------------
   assign o_prog_active = prog_active;
   assign o_prog_enable = mode & pe_ff;
   assign o_prog_supply_on = prog_active | (mode & pe_ff);
   // Only unprogrammed latched bytes count as a write waiting for enable
   assign o_standby = mode ? (sel_s & ~pe_ff & (page_vld == '0) & ~prog_active) :
                             ((tw_state == TW_STBY) & ~prog_active);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);

   sequence s_bad_opcode;
      fw_ev && fw_state == FW_OPC && !opc_known;
   endsequence

   sequence s_enabled_deselect;
      sel_rise && pe_ff && pend;
   endsequence

   sequence s_tw_nack;
      tw_ack_rise && tw_state == TW_RDATA && sda_s;
   endsequence

   reset_clear_a: assert property ($fell(i_srst) |-> addr == ADDR_RESET && !pe_ff && !prog_active && o_sda_oe_n)
      else $error("state not cleared by reset");
   tw_start_a: assert property (tw_start |=> tw_state == TW_CHIP && tw_cnt == 4'h0 && o_sda_oe_n)
      else $error("start not decoded");
   tw_foreign_a: assert property (tw_byte_done && tw_state == TW_CHIP && !tw_chip_ok && prog_active |=> prog_active)
      else $error("foreign address stopped programming");
   tw_prog_go_a: assert property ((tw_start || tw_stop) && pend |=> prog_active)
      else $error("programming not started");
   tw_sel_end_a: assert property (tw_sel_ok |=> !prog_active && !pend)
      else $error("valid selection did not end programming");
   tw_rd_inc_a: assert property (tw_byte_done && tw_state == TW_RDATA |=> addr == $past(addr) + 8'h01)
      else $error("read address not advanced");
   tw_nack_a: assert property (s_tw_nack |=> tw_state == TW_STBY ##1 o_sda_oe_n)
      else $error("no standby after missing acknowledge");
   fw_desel_a: assert property ($rose(sel_s) && mode |=> o_serial_data_out_oe_n [*2])
      else $error("output driven while deselected");
   fw_dead_a: assert property (s_bad_opcode |=> o_serial_data_out_oe_n && !pend && fw_state == FW_DEAD)
      else $error("bad opcode not blocked");
   fw_enable_a: assert property (fw_ev && fw_state == FW_OPC && lk_rx == OPC_PROG_EN |=> pe_ff && o_prog_supply_on && !prog_active)
      else $error("enable opcode not applied");
   fw_prog_go_a: assert property (s_enabled_deselect |=> prog_active)
      else $error("deselect did not start programming");
   fw_suspend_a: assert property (sel_fall |=> !prog_active && fw_state == FW_OPC && tx_hold == $past(addr))
      else $error("selection did not suspend programming");
endmodule // sep_port

// [dv/sep_fw_master.sv]
// Four-wire bus master model; link clock runs only inside a frame.
// Assumes the bench calls drop after the last xfer of each frame.
module sep_fw_master (
   // Link
   output logic o_sck,
   output logic o_sel_n,
   output logic o_sdi,
   input wire logic i_sdo
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_sck = 1'h0;
      o_sel_n = 1'h1;
      o_sdi = 1'h0;
   end
   // Opcode, then address, then data
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      if (o_sel_n) begin
         o_sel_n = 1'h0;
         #40;
      end
      for (int i = 7; i >= 0; i--) begin
         o_sdi = tx[i];
         #24 o_sck = 1'h1;
         rx[i] = i_sdo;
         #24 o_sck = 1'h0;
      end
      // Idle data line toggles so no stale bit looks valid
      o_sdi = ~o_sdi;
      #24;
   endtask
   task automatic drop();
      o_sel_n = 1'h1;
      #40;
   endtask
endmodule // sep_fw_master

// [dv/sep_port_bench.sv]
// Self-checking bench of the dual-mode serial EEPROM port.
// Assumes sep_fw_master as four-wire master; two-wire master is local.
module sep_port_bench
   import sep_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [7:0] tx; logic [7:0] ex; logic [4:0] f;} sep_row_t;
   logic i_sys_clk = 1'h0;
   logic i_srst = 1'h1;
   logic mode = 1'h1;
   logic scl = 1'h1;
   logic sda_m = 1'h1;
   logic sda_out, sda_oe_n, sck, sel_n, sdi, sdo, sdo_oe_n, sb, act, en, sup;
   logic [7:0] rx;
   logic [8:0] r;
   int failures = 0;
   int check_count = 0;
   // Pull-up on the open-drain data line
   wire sda = (~sda_m | (~sda_oe_n & ~sda_out)) ? 1'h0 : 1'h1;
   // Flags: check, frame end, enable, active, standby
   sep_row_t rows [11] = '{{OPC_WRITE, 8'h00, 5'h10}, {8'h10, 8'h00, 5'h10},
      {8'h11, 8'h10, 5'h10}, {8'h22, 8'h00, 5'h08}, {OPC_PROG_EN, 8'h12, 5'h1e},
      {OPC_PROG_DIS, 8'h12, 5'h19}, {OPC_READ, 8'h12, 5'h10}, {8'h10, 8'h00, 5'h10},
      {8'hff, 8'h10, 5'h10}, {8'hff, 8'h11, 5'h10}, {8'hff, 8'h22, 5'h19}};
   logic [7:0] tw_w [5] = '{8'ha4, 8'h20, 8'h5a, 8'ha5, 8'h3c};
   sep_port DUT (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_mode_sel(mode),
      .i_chip_sel_upper_pin(1'h1), .i_chip_sel_lower_pin(1'h0), .i_scl(scl), .i_sda(sda),
      .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .i_four_wire_clock_in(sck),
      .i_select_n_line(sel_n), .i_serial_data_in_line(sdi), .o_serial_data_out_line(sdo),
      .o_serial_data_out_oe_n(sdo_oe_n), .o_standby(sb), .o_prog_active(act),
      .o_prog_enable(en), .o_prog_supply_on(sup));
   sep_fw_master fw (.o_sck(sck), .o_sel_n(sel_n), .o_sdi(sdi), .i_sdo(sdo));
   initial forever #2 i_sys_clk = ~i_sys_clk;
   // --------
   // Tasks
   // --------
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic close_out();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Mode is frozen at reset, so each mode needs its own reset
   task automatic do_reset(input logic m);
      @(posedge i_sys_clk);
      i_srst <= 1'h1;
      mode <= m;
      repeat (4) @(posedge i_sys_clk);
      i_srst <= 1'h0;
      repeat (4) @(posedge i_sys_clk);
   endtask
   task automatic settle(input logic e);
      for (int k = 0; k < 16 && act !== e; k++) @(posedge i_sys_clk);
      #1;
   endtask
   task automatic tw_bit(input logic b, output logic q);
      @(posedge i_sys_clk);
      sda_m <= b;
      repeat (8) @(posedge i_sys_clk);
      scl <= 1'h1;
      repeat (4) @(posedge i_sys_clk);
      #1 q = sda;
      repeat (4) @(posedge i_sys_clk);
      scl <= 1'h0;
   endtask
   task automatic tw_byte(input logic [8:0] tx, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) tw_bit(tx[i], q[i]);
   endtask
   // Start when stop is 0, stop when 1
   task automatic tw_cond(input logic stop);
      @(posedge i_sys_clk);
      sda_m <= ~stop;
      repeat (4) @(posedge i_sys_clk);
      scl <= 1'h1;
      repeat (8) @(posedge i_sys_clk);
      sda_m <= stop;
      repeat (8) @(posedge i_sys_clk);
      scl <= stop;
   endtask
   initial begin
      #100us;
      failures++;
      close_out();
   end
   // --------
   // Sequence
   // --------
   initial begin
      do_reset(1'h1);
      chk("reset", {sb, en, sup, act, sda_oe_n, sdo_oe_n}, 8'h23);
      foreach (rows[i]) begin
         fw.xfer(rows[i].tx, rx);
         if (rows[i].f[4]) chk("fw_rx", rx, rows[i].ex);
         if (rows[i].f[3]) begin
            fw.drop();
            settle(rows[i].f[1]);
            chk("fw_flags", {en, act, sb}, rows[i].f[2:0]);
            chk("supply", sup, rows[i].f[2] | rows[i].f[1]);
         end
      end
      fw.xfer(8'h55, rx);
      chk("bad_opc", sdo_oe_n, 1'h1);
      fw.drop();
      chk("deselected", sdo_oe_n, 1'h1);
      do_reset(1'h0);
      tw_cond(1'h0);
      foreach (tw_w[i]) begin
         tw_byte({tw_w[i], 1'h1}, r);
         chk("tw_ack", r[0], 1'h0);
      end
      tw_cond(1'h1);
      settle(1'h1);
      chk("tw_prog", act, 1'h1);
      tw_cond(1'h0);
      tw_byte(9'h141, r);
      chk("tw_foreign", {r[0], act}, 2'h3);
      tw_cond(1'h0);
      tw_byte(9'h149, r);
      tw_byte(9'h041, r);
      settle(1'h0);
      chk("tw_prog_end", act, 1'h0);
      tw_cond(1'h0);
      tw_byte(9'h14b, r);
      tw_byte(9'h1fe, r);
      chk("tw_rd0", r[8:1], 8'h5a);
      tw_byte(9'h1ff, r);
      chk("tw_rd1", r[8:1], 8'ha5);
      tw_cond(1'h1);
      chk("tw_idle", {sb, sda_oe_n}, 2'h3);
      tw_cond(1'h0);
      tw_byte(9'h14b, r);
      tw_byte(9'h1ff, r);
      chk("tw_rd2", r[8:1], 8'h3c);
      tw_cond(1'h1);
      close_out();
   end
endmodule // sep_port_bench
